/* core/tmr_pkg.sv */
package tmr_pkg;

  // ==========================================================
  // Register map (word index on the plain register port).
  // ==========================================================
  localparam logic [2:0] ADDR_CTRL  = 3'h0;  // Timer control register.
  localparam logic [2:0] ADDR_CMPA  = 3'h1;  // Compare A register.
  localparam logic [2:0] ADDR_CMPB  = 3'h2;  // Compare B / capture register.
  localparam logic [2:0] ADDR_COUNT = 3'h3;  // Running up-counter, read only.
  localparam logic [2:0] ADDR_STAT  = 3'h4;  // Live status, read only.

  // ==========================================================
  // Control register field positions.
  // ==========================================================
  localparam int MODE_LSB    = 0;   // Mode select field, three bits.
  localparam int CLKSEL_LSB  = 3;   // Source clock select field, two bits.
  localparam int START_LSB   = 5;   // Start control field, two bits.
  localparam int ACAP_BIT    = 7;   // Auto-capture enable.
  localparam int MCAP_BIT    = 8;   // Capture mode select, 1 is single edge.
  localparam int ONESHOT_BIT = 9;   // One-shot select for pulse generation.
  localparam int PRESET_BIT  = 10;  // Output flop preset.
  localparam int CTRL_BITS   = 11;  // Implemented control bits.

  // ==========================================================
  // Reset values.
  // ==========================================================
  localparam logic [15:0] CTRL_RESET = 16'h0000;  // Timer mode, stopped.
  localparam logic [15:0] CMP_RESET  = 16'hffff;  // Compare registers.

  // ==========================================================
  // Start control field encodings.
  // ==========================================================
  localparam logic [1:0] START_STOP = 2'h0;  // Stopped, counter cleared.
  localparam logic [1:0] START_CMD  = 2'h1;  // Command start.
  localparam logic [1:0] START_RISE = 2'h2;  // Rising edge or positive window.
  localparam logic [1:0] START_FALL = 2'h3;  // Falling edge or negative window.

  // ==========================================================
  // Source clock divider masks, one per select code.
  // ==========================================================
  localparam logic [7:0] DIV_MASK0 = 8'hff;  // Tick every 256 clocks.
  localparam logic [7:0] DIV_MASK1 = 8'h0f;  // Tick every 16 clocks.
  localparam logic [7:0] DIV_MASK2 = 8'h03;  // Tick every 4 clocks.
  localparam logic [7:0] DIV_MASK3 = 8'h00;  // Tick every clock.

  // Operating modes.
  typedef enum logic [2:0] {
    MODE_TIMER  = 3'b000,
    MODE_EVENT  = 3'b010,
    MODE_WINDOW = 3'b011,
    MODE_PULSEW = 3'b110,
    MODE_PULGEN = 3'b111
  } tmr_mode_t;

  // Phase of the edge-started modes.
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ARMED = 2'b01,
    PH_RUN   = 2'b10
  } tmr_phase_t;

endpackage : tmr_pkg

/* core/tmr_event_capture.sv */
// Functional notes
// R1: Event mode counts selected external input edges.
// R2: Event compare-A match interrupts and clears counter.
// R3: Event match evaluated on opposite input edge.
// R4: Source holds input levels two machine cycles.
// R5: Auto-capture copies counter into compare B.
// R6: Software waits one source clock before reading.
// R7: Read auto-capture only while running and enabled.
// R8: Window mode counts gated source clock, compare-A.
// R9: Window pulse far slower than source clock.
// R10: Pulse width starts on trigger edge.
// R11: Single-edge: capture, interrupt, clear on opposite.
// R12: Single-edge counter rests at one after capture.
// R13: Double-edge captures both edges, clears on trigger.
// R14: Software reads capture before next trigger edge.
// R15: Software discards first pulse width capture.
// R16: Pulse generator starts by edge or command.
// R17: Continuous: toggle on B and A, A clears.
// R18: Start field 00 stops, output level held.
// R19: One-shot: A match clears start, halts.
// R20: Pin drives inverse of flop, reset zero.
// R21: Preset changed only via timer-mode reentry; the flop loads the preset bit in every mode except pulse generation.
// R22: Software keeps compare A above compare B.
// R23: Low-power stop clears start field, halts.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module tmr_event_capture (
  input  wire logic        clk,             // System clock, 25 MHz.
  input  wire logic        rst_n,           // Synchronous reset, active low.
  input  wire logic [2:0]  regAddr,         // Register word index.
  input  wire logic [15:0] regWdata,        // Register write data.
  input  wire logic        regWrite,        // Write strobe, one cycle.
  input  wire logic        regRead,         // Read strobe, one cycle.
  output logic      [15:0] regRdata,        // Read data, cycle after strobe.
  input  wire logic        timerExtInput,   // External count, window or trigger pin.
  input  wire logic        lowPowerStop,    // Entry pulse of the low-power stop state.
  output logic             pulseOutputPin,  // Pulse output, inverse of the flop.
  output logic             timerInterrupt   // One-cycle interrupt pulse.
);
  import tmr_pkg::*;

  // ==========================================================
  // Registers and state.
  // ==========================================================
  logic [CTRL_BITS-1:0] ctrl_q;      // Timer control register.
  logic [15:0]          cmpA_q;      // Compare A register.
  logic [15:0]          cmpB_q;      // Compare B / capture register.
  logic [15:0]          cnt_q;       // Up-counter.
  logic [15:0]          cnt_d;       // Next counter value.
  logic [7:0]           pre_q;       // Free-running prescaler.
  logic [2:0]           pinSync_q;   // Three-stage pin synchroniser.
  logic                 pinLvl_q;    // Accepted pin level.
  logic                 outFlop_q;   // Output flop.
  logic                 irq_d;       // Interrupt request this cycle.
  logic                 capEn;       // Load compare B from capture value.
  logic [15:0]          capVal;      // Value to capture.
  logic                 toggle;      // Invert the output flop.
  logic                 hwStop;      // Hardware clears the start field.
  tmr_phase_t           phase_q;     // Phase of edge-started modes.
  tmr_phase_t           phase_d;     // Next phase.

  // Decoded control fields.
  tmr_mode_t  mode;
  logic [1:0] startSel;
  logic [1:0] clkSel;
  logic       running;
  logic       fallSel;
  logic       tick;
  logic       pinRise;
  logic       pinFall;
  logic       selEdge;
  logic       oppEdge;
  logic [7:0] divMask;

  assign mode     = tmr_mode_t'(ctrl_q[MODE_LSB +: 3]);
  assign startSel = ctrl_q[START_LSB +: 2];
  assign clkSel   = ctrl_q[CLKSEL_LSB +: 2];
  assign running  = (startSel != START_STOP);
  assign fallSel  = (startSel == START_FALL);

  // ==========================================================
  // Source clock enable from the prescaler.
  // ==========================================================
  // Selects the mask whose low prescaler bits must all be ones.
  always_comb begin
    case (clkSel)
      2'h0:    divMask = DIV_MASK0;
      2'h1:    divMask = DIV_MASK1;
      2'h2:    divMask = DIV_MASK2;
      default: divMask = DIV_MASK3;
    endcase
  end

  assign tick = ((pre_q & divMask) == divMask);

  // Free-running prescaler; it never stops so the tick rate is steady.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // ==========================================================
  // Pin input synchroniser and edge detection.
  // ==========================================================
  // A level is accepted once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinSync_q <= 3'h0;
      pinLvl_q  <= 1'b0;
    end else begin
      pinSync_q <= {pinSync_q[1:0], timerExtInput};
      if (pinSync_q[1] == pinSync_q[2]) begin
        pinLvl_q <= pinSync_q[2];
      end
    end
  end

  // Edges come from the accepted level, never from the first stage.
  assign pinRise = (pinSync_q[1] == pinSync_q[2]) && pinSync_q[2] && !pinLvl_q;
  assign pinFall = (pinSync_q[1] == pinSync_q[2]) && !pinSync_q[2] && pinLvl_q;
  assign selEdge = fallSel ? pinFall : pinRise;
  assign oppEdge = fallSel ? pinRise : pinFall;

  // ==========================================================
  // Counter, capture and output control per mode.
  // ==========================================================
  // Works out the next counter, phase and the side effects.
  always_comb begin
    cnt_d   = cnt_q;
    phase_d = phase_q;
    irq_d   = 1'b0;
    capEn   = 1'b0;
    capVal  = cnt_q;
    toggle  = 1'b0;
    hwStop  = 1'b0;
    if (!running) begin  // R18
      // Stopped: counter cleared, edge-started modes re-arm, no toggle so the flop holds.
      cnt_d   = 16'h0000;
      phase_d = PH_IDLE;
    end else begin
      case (mode)
        MODE_EVENT: begin
          if (selEdge) begin
            cnt_d = cnt_q + 16'h0001;  // R1
          end else if (oppEdge && (cnt_q == cmpA_q)) begin
            irq_d = 1'b1;  // R3
            cnt_d = 16'h0000;  // R2
          end
          // Auto-capture runs on the counter's own source clock.
          if (ctrl_q[ACAP_BIT] && selEdge) begin
            capEn = 1'b1;  // R5
          end
        end
        MODE_WINDOW: begin
          // Source clock ANDed with the window level, polarity chosen.
          if (tick && (pinLvl_q != fallSel)) begin
            if (cnt_q == cmpA_q) begin
              irq_d = 1'b1;  // R8
              cnt_d = 16'h0000;  // R8
            end else begin
              cnt_d = cnt_q + 16'h0001;  // R8
            end
          end
          if (ctrl_q[ACAP_BIT] && tick) begin
            capEn = 1'b1;  // R5
          end
        end
        MODE_TIMER: begin
          // Timer mode does not count; the counter holds its value, capture still works.
          if (ctrl_q[ACAP_BIT] && tick) begin
            capEn = 1'b1;  // R5
          end
        end
        MODE_PULSEW: begin
          case (phase_q)
            PH_RUN: begin
              if (oppEdge) begin
                capEn = 1'b1;  // R11
                irq_d = 1'b1;  // R11
                if (ctrl_q[MCAP_BIT]) begin
                  cnt_d   = 16'h0001;  // R12
                  phase_d = PH_ARMED;  // R11
                end else if (tick) begin
                  cnt_d = cnt_q + 16'h0001;  // R13
                end
              end else if (selEdge && !ctrl_q[MCAP_BIT]) begin
                capEn = 1'b1;  // R13
                irq_d = 1'b1;  // R13
                cnt_d = 16'h0000;  // R13
              end else if (tick) begin
                cnt_d = cnt_q + 16'h0001;  // R10
              end
            end
            default: begin
              // Waiting for the trigger edge; the counter rests.
              if (selEdge) begin
                phase_d = PH_RUN;  // R10
              end
            end
          endcase
        end
        MODE_PULGEN: begin
          case (phase_q)
            PH_RUN: begin
              if (tick) begin
                if (cnt_q == cmpA_q) begin
                  toggle = 1'b1;  // R17
                  irq_d  = 1'b1;  // R17
                  cnt_d  = 16'h0000;  // R17
                  hwStop = ctrl_q[ONESHOT_BIT];  // R19
                end else begin
                  if (cnt_q == cmpB_q) begin
                    toggle = 1'b1;  // R17
                    irq_d  = 1'b1;  // R17
                  end
                  cnt_d = cnt_q + 16'h0001;  // R17
                end
              end
            end
            default: begin
              // Command start runs at once, edge start waits.
              if ((startSel == START_CMD) || selEdge) begin
                phase_d = PH_RUN;  // R16
              end
            end
          endcase
        end
        default: begin
          cnt_d = cnt_q;
        end
      endcase
    end
  end

  // Counter and phase update.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q   <= 16'h0000;
      phase_q <= PH_IDLE;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
    end
  end

  // Output flop: preset outside pulse generation, held when stopped.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outFlop_q <= 1'b0;  // R20
    end else if (mode != MODE_PULGEN) begin
      outFlop_q <= ctrl_q[PRESET_BIT];  // R20
    end else if (toggle) begin
      outFlop_q <= !outFlop_q;  // R17
    end
  end

  assign pulseOutputPin = !outFlop_q;  // R20

  // Interrupt pulse, registered.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timerInterrupt <= 1'b0;
    end else begin
      timerInterrupt <= irq_d;
    end
  end

  // ==========================================================
  // Register file.
  // ==========================================================
  // Control: stop entry wins, then a software write, then one-shot end.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET[CTRL_BITS-1:0];
    end else if (lowPowerStop) begin
      ctrl_q[START_LSB +: 2] <= START_STOP;  // R23
    end else if (regWrite && (regAddr == ADDR_CTRL)) begin
      ctrl_q <= regWdata[CTRL_BITS-1:0];
    end else if (hwStop) begin
      ctrl_q[START_LSB +: 2] <= START_STOP;  // R19
    end
  end

  // Compare A, written by software only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmpA_q <= CMP_RESET;
    end else if (regWrite && (regAddr == ADDR_CMPA)) begin
      cmpA_q <= regWdata;
    end
  end

  // Compare B: a hardware capture wins over a software write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmpB_q <= CMP_RESET;
    end else if (capEn) begin
      cmpB_q <= capVal;  // R5
    end else if (regWrite && (regAddr == ADDR_CMPB)) begin
      cmpB_q <= regWdata;
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        ADDR_CTRL:  regRdata <= {{(16-CTRL_BITS){1'b0}}, ctrl_q};
        ADDR_CMPA:  regRdata <= cmpA_q;
        ADDR_CMPB:  regRdata <= cmpB_q;
        ADDR_COUNT: regRdata <= cnt_q;
        ADDR_STAT:  regRdata <= {11'h000, phase_q, running, outFlop_q, pinLvl_q};
        default:    regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

endmodule : tmr_event_capture

`default_nettype wire

/* verification/tmr_ext_source.sv */
`timescale 1ns/100ps
`default_nettype none
// Far-side source on the timer input pin; it follows the level the bench
// asks for, but never leaves a level before the hold time has run out.
module tmr_ext_source #(
  parameter int HOLD = 4  // Each level is held at least HOLD + 1 cycles.
) (
  input  wire logic clk,      // System clock.
  input  wire logic rst_n,    // Synchronous reset, active low.
  input  wire logic reqLevel, // Level the bench asks for.
  output logic      pinLevel  // Level driven onto the pin.
);
  int holdCnt;  // Cycles spent at the present level.
  // A request is taken only once the hold count is used up.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinLevel <= 1'b0;
      holdCnt  <= 0;
    end else if (holdCnt < HOLD) begin
      holdCnt <= holdCnt + 1;
    end else if (reqLevel != pinLevel) begin
      pinLevel <= reqLevel;
      holdCnt  <= 0;
    end
  end
endmodule : tmr_ext_source
`default_nettype wire

/* verification/tmr_event_capture_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Port checker; a shadow of software writes supplies the context.
module tmr_event_capture_checker
  import tmr_pkg::*;
(
  input wire logic        clk,            // Clock.
  input wire logic        rst_n,          // Reset.
  input wire logic [2:0]  regAddr,        // Index.
  input wire logic [15:0] regWdata,       // Write data.
  input wire logic        regWrite,       // Write.
  input wire logic        regRead,        // Read.
  input wire logic [15:0] regRdata,       // Read data.
  input wire logic        timerExtInput,  // Pin in.
  input wire logic        lowPowerStop,   // Stop entry.
  input wire logic        pulseOutputPin, // Pin out.
  input wire logic        timerInterrupt  // Interrupt.
);
  logic [2:0]  mode_q;   // Mode last written.
  logic [1:0]  start_q;  // Start field as software left it.
  logic        preset_q; // Preset bit last written.
  logic [15:0] cmpa_q;   // Compare A last written.
  logic        pg;       // Pulse generator mode.
  assign pg = (mode_q == MODE_PULGEN);
  // Track writes; stop entry wins over a write to the start field.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q   <= 3'h0;
      start_q  <= 2'h0;
      preset_q <= 1'b0;
      cmpa_q   <= CMP_RESET;
    end else begin
      if (regWrite && regAddr == ADDR_CTRL) begin
        mode_q   <= regWdata[2:0];
        start_q  <= regWdata[6:5];
        preset_q <= regWdata[PRESET_BIT];
      end
      if (regWrite && regAddr == ADDR_CMPA) begin
        cmpa_q <= regWdata;
      end
      if (lowPowerStop) begin
        start_q <= START_STOP;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Assertions.
  // ==========================================================
  reset_pin_a: assert property (disable iff (1'b0)
    !rst_n |=> pulseOutputPin && !timerInterrupt) else $error("Reset outputs wrong.");
  idle_pin_a: assert property (!pg && !$past(pg) && $stable(preset_q)
    |-> pulseOutputPin == !preset_q) else $error("Pin not inverse of preset.");
  pgen_toggle_a: assert property ($changed(pulseOutputPin) && pg && $past(pg)
    && $past(pg, 2) |-> timerInterrupt) else $error("Toggle without interrupt.");
  stop_hold_a: assert property (pg && $past(pg) && start_q == START_STOP
    && $past(start_q) == START_STOP |-> $stable(pulseOutputPin)) else $error("Pin moved.");
  stop_quiet_a: assert property (start_q == START_STOP
    && $past(start_q) == START_STOP |-> !timerInterrupt) else $error("Stopped irq.");
  lps_quiet_a: assert property (lowPowerStop |-> ##2 !timerInterrupt)
    else $error("Interrupt after stop entry.");
  cmpa_read_a: assert property (regRead && regAddr == ADDR_CMPA
    |=> regRdata == cmpa_q) else $error("Compare A readback wrong.");
  ctrl_read_a: assert property (regRead && regAddr == ADDR_CTRL
    |=> regRdata[2:0] == mode_q && regRdata[10] == preset_q) else $error("Ctrl wrong.");
  rdata_idle_a: assert property (!regRead |=> regRdata == 16'h0000)
    else $error("Read data not idle.");
  pgen_irq_c: cover property (pg && timerInterrupt);
  width_irq_c: cover property (mode_q == MODE_PULSEW && timerInterrupt);
  stop_entry_c: cover property (lowPowerStop);
endmodule : tmr_event_capture_checker
`default_nettype wire

/* verification/tmr_event_capture_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tmr_event_capture_tb_top;
  import tmr_pkg::*;
  logic        clk = 1'b0;          // 25 MHz clock.
  logic        rst_n = 1'b0;        // Reset, active low.
  logic [2:0]  regAddr = 3'h0;      // Register index.
  logic [15:0] regWdata = 16'h0000; // Write data.
  logic        regWrite = 1'b0;     // Write strobe.
  logic        regRead = 1'b0;      // Read strobe.
  logic        lowPowerStop = 1'b0; // Stop-state entry.
  logic        reqLevel = 1'b0;     // Level asked of the source.
  logic        timerExtInput;       // Pin from the source.
  logic [15:0] regRdata;            // Read data.
  logic        pulseOutputPin;      // Pulse output.
  logic        timerInterrupt;      // Interrupt pulse.
  logic [15:0] rv;                  // Last value read.
  logic [15:0] cap [4];             // Captures after each edge.
  logic [1:0]  evEdge [2] = '{START_RISE, START_FALL};  // Edge choices.
  int          errorCnt = 0;        // Mismatches.
  int          comparisons = 0;     // Comparisons made.
  int          irqCnt = 0;          // Interrupts seen.
  int          n0;                  // Interrupt count at test start.
  int          n;                   // Cycles waited.
  tmr_event_capture tmr_event_capture_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .timerExtInput(timerExtInput), .lowPowerStop(lowPowerStop),
    .pulseOutputPin(pulseOutputPin), .timerInterrupt(timerInterrupt));
  tmr_ext_source tmr_ext_source_i (.clk(clk), .rst_n(rst_n), .reqLevel(reqLevel),
    .pinLevel(timerExtInput));
  always #20 clk = ~clk;
  // Count interrupt pulses for the tests.
  always @(posedge clk) if (timerInterrupt === 1'b1) irqCnt <= irqCnt + 1;
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
    @(posedge clk);
  endtask : rd
  task automatic lvl(input logic b);
    reqLevel <= b;
    @(posedge clk);
  endtask : lvl
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Wait for the next interrupt, returning the cycles spent.
  task automatic waitIrq(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (timerInterrupt !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      chk(16'h0000, 16'h0001);
      conclude();
    end
  endtask : waitIrq
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL, rv); chk(rv, CTRL_RESET);
    rd(ADDR_CMPB, rv); chk(rv, CMP_RESET);
    rd(3'h7, rv); chk(rv, 16'h0000);
    chk(16'(pulseOutputPin), 16'h0001);
    $display("Test reset done");
    // Event counting on each edge choice, auto-capture on.
    wr(ADDR_CMPA, 16'h0002);
    foreach (evEdge[i]) begin
      wr(ADDR_CTRL, 16'h0000);
      lvl(evEdge[i] != START_RISE); cyc(8);
      n0 = irqCnt;
      wr(ADDR_CTRL, {8'h00, 1'b1, evEdge[i], 2'h3, MODE_EVENT});
      for (int k = 1; k <= 2; k++) begin
        lvl(evEdge[i] == START_RISE); cyc(8);
        rd(ADDR_COUNT, rv); chk(rv, 16'(k));
        rd(ADDR_CMPB, rv); chk(rv, 16'(k - 1));
        chk(16'(irqCnt - n0), 16'h0000);
        lvl(evEdge[i] != START_RISE); cyc(8);
      end
      chk(16'(irqCnt - n0), 16'h0001);
      rd(ADDR_COUNT, rv); chk(rv, 16'h0000);
    end
    $display("Test event done");
    // Pulse width, single edge then double edge; each level 20 cycles.
    for (int m = 1; m >= 0; m--) begin
      wr(ADDR_CTRL, 16'h0000);
      lvl(1'b0); cyc(8);
      n0 = irqCnt;
      wr(ADDR_CTRL, {7'h00, 1'(m), 1'b0, START_RISE, 2'h3, MODE_PULSEW});
      for (int p = 0; p < 4; p++) begin
        lvl(!p[0]); cyc(9);
        rd(ADDR_CMPB, cap[p]); cyc(8);
      end
      if (m == 1) begin
        chk(cap[2], cap[1]);
        chk(cap[3], cap[1] + 16'h0001);
        chk(16'(irqCnt - n0), 16'h0002);
      end else begin
        chk(cap[2], cap[1] + 16'h0014);
        chk(16'(irqCnt - n0), 16'h0003);
      end
    end
    $display("Test width done");
    // Window: closed gate holds the count, open gate counts to compare A.
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CMPA, 16'h0005);
    n0 = irqCnt;
    wr(ADDR_CTRL, {9'h000, START_RISE, 2'h3, MODE_WINDOW});
    cyc(20); rd(ADDR_COUNT, rv); chk(rv, 16'h0000);
    lvl(1'b1); cyc(40);
    lvl(1'b0); cyc(8);
    chk(16'(irqCnt > n0), 16'h0001);
    rd(ADDR_COUNT, rv); cyc(10); rd(ADDR_COUNT, cap[0]); chk(cap[0], rv);
    $display("Test window done");
    // Continuous pulse generation, stop, then stop-state entry.
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, {9'h000, START_STOP, 2'h3, MODE_PULGEN});
    wr(ADDR_CMPA, 16'h000a); wr(ADDR_CMPB, 16'h0004);
    wr(ADDR_CTRL, {9'h000, START_CMD, 2'h3, MODE_PULGEN});
    waitIrq(n); chk(16'(pulseOutputPin), 16'h0000);
    waitIrq(n); chk(16'(n), 16'h0006); chk(16'(pulseOutputPin), 16'h0001);
    waitIrq(n); chk(16'(n), 16'h0005); chk(16'(pulseOutputPin), 16'h0000);
    wr(ADDR_CTRL, {9'h000, START_STOP, 2'h3, MODE_PULGEN});
    cyc(30); chk(16'(pulseOutputPin), 16'h0000);
    wr(ADDR_CTRL, {9'h000, START_CMD, 2'h3, MODE_PULGEN});
    cyc(3); lowPowerStop <= 1'b1;
    @(posedge clk); lowPowerStop <= 1'b0;
    rd(ADDR_CTRL, rv); chk(rv, {9'h000, START_STOP, 2'h3, MODE_PULGEN});
    $display("Test pulse done");
    // Preset in timer mode, then a one-shot pulse.
    wr(ADDR_CTRL, 16'h0400); cyc(2); chk(16'(pulseOutputPin), 16'h0000);
    wr(ADDR_CTRL, 16'h0000);
    n0 = irqCnt;
    wr(ADDR_CTRL, {6'h00, 1'b1, 2'h0, START_CMD, 2'h3, MODE_PULGEN});
    waitIrq(n); waitIrq(n); chk(16'(pulseOutputPin), 16'h0001);
    rd(ADDR_CTRL, rv); chk(16'(rv[6:5]), 16'h0000);
    cyc(40); chk(16'(irqCnt - n0), 16'h0002);
    // Edge-started one-shot on the divide-by-four source clock.
    n0 = irqCnt;
    wr(ADDR_CTRL, {6'h00, 1'b1, 2'h0, START_RISE, 2'h2, MODE_PULGEN});
    cyc(20); chk(16'(irqCnt - n0), 16'h0000);
    lvl(1'b1); waitIrq(n); waitIrq(n); chk(16'(n), 16'h0018);
    chk(16'(pulseOutputPin), 16'h0001);
    $display("Test one-shot done");
    conclude();
  end
endmodule : tmr_event_capture_tb_top
bind tmr_event_capture tmr_event_capture_checker tmr_event_capture_checker_i (.clk(clk),
  .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .timerExtInput(timerExtInput),
  .lowPowerStop(lowPowerStop), .pulseOutputPin(pulseOutputPin),
  .timerInterrupt(timerInterrupt));
`default_nettype wire
